// ==== rtl/chst_pkg.sv ====
/*
 * chst_pkg: command codes, field positions, reset values and timing
 * constants of the charger status / processor-hot register pair.
 * assumes a 10 MHz core clock.
 */
package chst_pkg;
    localparam logic [7:0] CHST_ADDR_STATE = 8'h20;
    localparam logic [7:0] CHST_ADDR_HOT = 8'h21;
    localparam logic [15:0] CHST_HOT_RESET = 16'hb800;
    localparam logic [15:0] CHST_ZERO16 = 16'h0000;

    // charger_state_and_faults fields
    localparam int CHST_B_PRECHG = 9;
    localparam int CHST_B_REVSUP = 8;
    localparam int CHST_B_IN_OV = 7;
    localparam int CHST_B_BAT_OC = 6;
    localparam int CHST_B_IN_OC = 5;
    localparam int CHST_B_SYS_OV = 4;
    localparam int CHST_B_SYS_UV = 3;
    localparam int CHST_B_CONV_OFF = 2;
    localparam int CHST_B_REV_OV = 1;
    localparam int CHST_B_REV_UV = 0;

    // hot_signal_status_control fields
    localparam int CHST_B_RSVD = 15;
    localparam int CHST_B_EXT_EN = 14;
    localparam int CHST_B_WIDTH_HI = 13;
    localparam int CHST_B_WIDTH_LO = 12;
    localparam int CHST_B_RELEASE = 11;
    localparam int CHST_B_THERMAL_SHUTDOWN_FLAG = 10;
    localparam int CHST_B_ASSIST_FAIL = 9;
    localparam int CHST_B_ASSIST_EXIT = 8;
    localparam int CHST_PROF_N = 7;
    localparam logic [1:0] CHST_WIDTH_RESET = 2'h3;

    // synchronised pin vector positions
    localparam int CHST_S_PRECHG = 0;
    localparam int CHST_S_REVSUP = 1;
    localparam int CHST_S_IN_OV = 2;
    localparam int CHST_S_IN_OC = 3;
    localparam int CHST_S_BAT_OC = 4;
    localparam int CHST_S_BAT_OV = 5;
    localparam int CHST_S_SYS_OV = 6;
    localparam int CHST_S_SYS_UV = 7;
    localparam int CHST_S_REV_OV = 8;
    localparam int CHST_S_REV_UV = 9;
    localparam int CHST_S_THERMAL_SHUTDOWN_FLAG = 10;
    localparam int CHST_S_ASSIST_FAIL = 11;
    localparam int CHST_S_ADAPTER = 12;
    localparam int CHST_S_PROF = 13;
    localparam int CHST_SYNC_W = CHST_S_PROF + CHST_PROF_N;

    // hot pulse timing: one tick per 100 us, widths counted in ticks
    localparam int CHST_CLK_PERIOD_NS = 100;
    localparam int CHST_TICK_US = 100;
    localparam int CHST_TICK_CYC = (CHST_TICK_US * 1000) / CHST_CLK_PERIOD_NS;
    localparam int CHST_W0_US = 100;
    localparam int CHST_W1_US = 1000;
    localparam int CHST_W2_US = 5000;
    localparam int CHST_W3_US = 10000;
    localparam logic [6:0] CHST_W0_TICKS = 7'(CHST_W0_US / CHST_TICK_US);
    localparam logic [6:0] CHST_W1_TICKS = 7'(CHST_W1_US / CHST_TICK_US);
    localparam logic [6:0] CHST_W2_TICKS = 7'(CHST_W2_US / CHST_TICK_US);
    localparam logic [6:0] CHST_W3_TICKS = 7'(CHST_W3_US / CHST_TICK_US);
endpackage : chst_pkg

// ==== rtl/chst_tmr_if.sv ====
/*
 * chst_tmr_if: link between the register logic and the hot pulse timer.
 * assumes both ends on the core clock.
 */
interface chst_tmr_if;
    logic start;
    logic [1:0] width;
    logic busy;
    modport ctl (output start, output width, input busy);
    modport tmr (input start, input width, output busy);
endinterface : chst_tmr_if

// ==== rtl/chst_hot_timer.sv ====
/*
 * chst_hot_timer: minimum-width timer for the processor-hot pulse.
 * assumes start is a one-cycle pulse on the core clock.
 */
module chst_hot_timer
    import chst_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    chst_tmr_if.tmr tmr
);
    logic [15:0] div_reg;
    logic [6:0] left_reg;
    logic tick;

    function automatic logic [6:0] width_ticks(input logic [1:0] code);
        unique case (code)
            2'h0: width_ticks = CHST_W0_TICKS;
            2'h1: width_ticks = CHST_W1_TICKS;
            2'h2: width_ticks = CHST_W2_TICKS;
            2'h3: width_ticks = CHST_W3_TICKS;
        endcase
    endfunction : width_ticks

    assign tick = (div_reg == 16'(CHST_TICK_CYC - 1));

    // divider restarts on start so the width is never short
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || tmr.start || tick) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            left_reg <= 7'h00;
        end else if (tmr.start) begin
            left_reg <= width_ticks(tmr.width);
        end else if (tick && left_reg != 7'h00) begin
            left_reg <= left_reg - 7'h01;
        end
    end

    assign tmr.busy = (left_reg != 7'h00);
endmodule : chst_hot_timer

// ==== rtl/chst_status_regs.sv ====
/*
 * chst_status_regs: charger state/fault register and processor-hot
 * status/control register, with the processor-hot output.
 * assumes an upstream bus engine delivers one-cycle read/write commands
 * with a command code on the core clock; fault pins are async, mode pins arrive on the core clock.
 */
module chst_status_regs
    import chst_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_cmd_addr,
    input wire logic i_cmd_rd,
    input wire logic i_cmd_wr,
    input wire logic [15:0] i_cmd_wdata,
    input wire logic i_precharge,
    input wire logic i_reverse_supply,
    input wire logic i_input_ov,
    input wire logic i_input_oc,
    input wire logic i_battery_oc,
    input wire logic i_battery_ov,
    input wire logic i_system_ov,
    input wire logic i_system_uv_fail,
    input wire logic i_reverse_ov,
    input wire logic i_reverse_uv,
    input wire logic i_thermal_shutdown,
    input wire logic i_assist_load_fail,
    input wire logic i_adapter_present,
    input wire logic [6:0] i_profile_event,
    input wire logic i_pass_through,
    input wire logic i_battery_oc_enable,
    input wire logic i_converter_shutoff_request,
    input wire logic i_assist_request,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_processor_hot_n,
    output logic o_converter_disable,
    output logic o_assist_active
);
    logic [CHST_SYNC_W-1:0] pins;
    logic [CHST_SYNC_W-1:0] meta_reg;
    logic [CHST_SYNC_W-1:0] sync_reg;
    logic [CHST_PROF_N-1:0] prof_prev_reg;
    logic [9:0] state_reg;
    logic [15:0] hot_reg;
    logic ext_hold_reg;
    logic assist_req_prev_reg;
    logic rd_state;
    logic rd_hot;
    logic wr_state;
    logic wr_hot;
    logic bat_oc_evt;
    logic assist_fault;
    logic assist_end;
    logic hot_trigger;
    logic release_wr;
    logic hot_hold;
    logic [9:0] state_set;
    logic [9:0] state_clr;
    chst_tmr_if tmr_if ();

    chst_hot_timer u_timer (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .tmr(tmr_if.tmr)
    );

    function automatic logic wr_zero(input logic wr, input logic [15:0] d, input int b);
        wr_zero = wr && !d[b];
    endfunction : wr_zero

    function automatic logic cmd_hit(input logic strobe, input logic [7:0] addr,
                                     input logic [7:0] code);
        cmd_hit = strobe && (addr == code);
    endfunction : cmd_hit

    // one sticky bit: set, else keep unless cleared
    function automatic logic hold_flag(input logic set, input logic cur, input logic clr);
        hold_flag = set || (cur && !clr);
    endfunction : hold_flag

    // unmapped codes answer zero so a stray address never shows a flag
    function automatic logic [15:0] read_word(input logic [7:0] addr, input logic [9:0] st,
                                              input logic [15:0] hot);
        if (addr == CHST_ADDR_STATE) begin
            read_word = 16'(st);
        end else if (addr == CHST_ADDR_HOT) begin
            read_word = hot;
        end else begin
            read_word = CHST_ZERO16;
        end
    endfunction : read_word

    assign pins = {i_profile_event, i_adapter_present, i_assist_load_fail,
                   i_thermal_shutdown, i_reverse_uv, i_reverse_ov, i_system_uv_fail,
                   i_system_ov, i_battery_ov, i_battery_oc, i_input_oc, i_input_ov,
                   i_reverse_supply, i_precharge};

    // pins are analog detector outputs, asynchronous to the core clock
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
        end
    end

    // the upstream engine never raises rd and wr in one cycle
    assign rd_state = cmd_hit(i_cmd_rd, i_cmd_addr, CHST_ADDR_STATE);
    assign rd_hot = cmd_hit(i_cmd_rd, i_cmd_addr, CHST_ADDR_HOT);
    assign wr_state = cmd_hit(i_cmd_wr, i_cmd_addr, CHST_ADDR_STATE);
    assign wr_hot = cmd_hit(i_cmd_wr, i_cmd_addr, CHST_ADDR_HOT);

    // outside pass-through only overcurrent counts
    assign bat_oc_evt = i_pass_through
        ? (i_battery_oc_enable && (sync_reg[CHST_S_BAT_OC] || sync_reg[CHST_S_BAT_OV]))
        : sync_reg[CHST_S_BAT_OC];

    always_comb begin
        state_set = 10'h000;
        state_set[CHST_B_IN_OV] = sync_reg[CHST_S_IN_OV];
        state_set[CHST_B_IN_OC] = sync_reg[CHST_S_IN_OC];
        state_set[CHST_B_BAT_OC] = bat_oc_evt;
        state_set[CHST_B_CONV_OFF] = i_converter_shutoff_request;
        state_set[CHST_B_REV_OV] = sync_reg[CHST_S_REV_OV];
        state_set[CHST_B_REV_UV] = sync_reg[CHST_S_REV_UV];
        state_set[CHST_B_SYS_OV] = sync_reg[CHST_S_SYS_OV] && sync_reg[CHST_S_ADAPTER];
        state_set[CHST_B_SYS_UV] = sync_reg[CHST_S_SYS_UV];
        state_clr = {10{rd_state}};
        state_clr[CHST_B_PRECHG] = 1'b0;
        state_clr[CHST_B_REVSUP] = 1'b0;
        // these two clear only by write of 0; unplug also clears overvoltage
        state_clr[CHST_B_SYS_OV] = wr_zero(wr_state, i_cmd_wdata, CHST_B_SYS_OV)
            || !sync_reg[CHST_S_ADAPTER];
        state_clr[CHST_B_SYS_UV] = wr_zero(wr_state, i_cmd_wdata, CHST_B_SYS_UV);
    end

    // sticky flags: a set in the clearing cycle wins
    for (genvar g = CHST_B_REV_UV; g <= CHST_B_IN_OV; g++) begin : g_sticky
        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
                state_reg[g] <= 1'b0;
            end else begin
                state_reg[g] <= hold_flag(state_set[g], state_reg[g], state_clr[g]);
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_reg[CHST_B_PRECHG] <= 1'b0;
            state_reg[CHST_B_REVSUP] <= 1'b0;
        end else begin
            state_reg[CHST_B_PRECHG] <= sync_reg[CHST_S_PRECHG];
            state_reg[CHST_B_REVSUP] <= sync_reg[CHST_S_REVSUP];
        end
    end

    // registered so the converter never sees a decode glitch
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_converter_disable <= 1'b0;
        end else begin
            o_converter_disable <= state_reg[CHST_B_SYS_OV];
        end
    end

    // assist mode
    assign assist_fault = sync_reg[CHST_S_IN_OV] || sync_reg[CHST_S_IN_OC]
        || sync_reg[CHST_S_SYS_OV] || sync_reg[CHST_S_BAT_OV] || sync_reg[CHST_S_SYS_UV];
    assign assist_end = o_assist_active
        && (!i_assist_request || assist_fault || sync_reg[CHST_S_ASSIST_FAIL]);

    // entry needs a fresh request edge so a fault exit stays off
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_assist_active <= 1'b0;
            assist_req_prev_reg <= 1'b0;
        end else begin
            assist_req_prev_reg <= i_assist_request;
            if (assist_end) begin
                o_assist_active <= 1'b0;
            end else if (i_assist_request && !assist_req_prev_reg
                         && !hot_reg[CHST_B_ASSIST_FAIL] && !assist_fault) begin
                o_assist_active <= 1'b1;
            end
        end
    end

    // hot register: write fields
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            hot_reg[CHST_B_EXT_EN] <= CHST_HOT_RESET[CHST_B_EXT_EN];
            hot_reg[CHST_B_WIDTH_HI:CHST_B_WIDTH_LO] <= CHST_WIDTH_RESET;
        end else if (wr_hot) begin
            hot_reg[CHST_B_EXT_EN] <= i_cmd_wdata[CHST_B_EXT_EN];
            hot_reg[CHST_B_WIDTH_HI:CHST_B_WIDTH_LO] <=
                i_cmd_wdata[CHST_B_WIDTH_HI:CHST_B_WIDTH_LO];
        end
    end

    // reserved bit and release bit read fixed; release acts, then reads idle
    always_ff @(posedge i_mclk) begin
        hot_reg[CHST_B_RSVD] <= CHST_HOT_RESET[CHST_B_RSVD];
        hot_reg[CHST_B_RELEASE] <= CHST_HOT_RESET[CHST_B_RELEASE];
        hot_reg[CHST_PROF_N] <= 1'b0;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            hot_reg[CHST_B_THERMAL_SHUTDOWN_FLAG] <= 1'b0;
        end else begin
            hot_reg[CHST_B_THERMAL_SHUTDOWN_FLAG] <= sync_reg[CHST_S_THERMAL_SHUTDOWN_FLAG]
                || (hot_reg[CHST_B_THERMAL_SHUTDOWN_FLAG] && !rd_hot);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            hot_reg[CHST_B_ASSIST_FAIL] <= 1'b0;
            hot_reg[CHST_B_ASSIST_EXIT] <= 1'b0;
        end else begin
            hot_reg[CHST_B_ASSIST_FAIL] <= (o_assist_active && sync_reg[CHST_S_ASSIST_FAIL])
                || (hot_reg[CHST_B_ASSIST_FAIL]
                    && !wr_zero(wr_hot, i_cmd_wdata, CHST_B_ASSIST_FAIL));
            hot_reg[CHST_B_ASSIST_EXIT] <= assist_end
                || (hot_reg[CHST_B_ASSIST_EXIT]
                    && !wr_zero(wr_hot, i_cmd_wdata, CHST_B_ASSIST_EXIT));
        end
    end

    // profile trigger flags
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            prof_prev_reg <= '0;
        end else begin
            prof_prev_reg <= sync_reg[CHST_S_PROF +: CHST_PROF_N];
        end
    end

    for (genvar p = 0; p < CHST_PROF_N; p++) begin : g_prof
        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
                hot_reg[p] <= 1'b0;
            end else begin
                hot_reg[p] <= hold_flag(sync_reg[CHST_S_PROF + p], hot_reg[p], rd_hot);
            end
        end
    end

    // a new profile event restarts the pulse
    assign hot_trigger = |(sync_reg[CHST_S_PROF +: CHST_PROF_N] & ~prof_prev_reg);
    assign release_wr = wr_zero(wr_hot, i_cmd_wdata, CHST_B_RELEASE);
    assign tmr_if.start = hot_trigger;
    assign tmr_if.width = hot_reg[CHST_B_WIDTH_HI:CHST_B_WIDTH_LO];

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ext_hold_reg <= 1'b0;
        end else if (hot_trigger && hot_reg[CHST_B_EXT_EN]) begin
            ext_hold_reg <= 1'b1;
        end else if (release_wr) begin
            ext_hold_reg <= 1'b0;
        end
    end

    // timer busy covers the min width even when extension is on
    assign hot_hold = tmr_if.busy || ext_hold_reg || hot_reg[CHST_B_ASSIST_EXIT];

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_processor_hot_n <= 1'b1;
        end else begin
            o_processor_hot_n <= !hot_hold;
        end
    end

    // read answer: value before the read's own clear
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_rd_data <= CHST_ZERO16;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_cmd_rd;
            if (i_cmd_rd) begin
                o_rd_data <= read_word(i_cmd_addr, state_reg, hot_reg);
            end
        end
    end
endmodule : chst_status_regs

// ==== testbench/chst_host_model.sv ====
/*
 * chst_host_model: host end of the register command port.
 * assumes the core clock; requests change 1 ns after a rising edge.
 */
module chst_host_model (
    input wire logic i_mclk,
    input wire logic [15:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic [7:0] o_cmd_addr,
    output logic o_cmd_rd,
    output logic o_cmd_wr,
    output logic [15:0] o_cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_cmd_addr = 8'h00;
        o_cmd_rd = 1'h0;
        o_cmd_wr = 1'h0;
        o_cmd_wdata = 16'h0000;
    end

    // released lines show the inverse so stale values never pass
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        #1;
        o_cmd_addr = a;
        o_cmd_rd = 1'h1;
        @(posedge i_mclk);
        #1;
        o_cmd_rd = 1'h0;
        o_cmd_addr = ~a;
        for (int n = 0; n < 3 && i_rd_valid !== 1'h1; n++) begin
            @(posedge i_mclk);
            #1;
        end
        d = (i_rd_valid === 1'h1) ? i_rd_data : 16'hxxxx;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        #1;
        o_cmd_addr = a;
        o_cmd_wdata = d;
        o_cmd_wr = 1'h1;
        @(posedge i_mclk);
        #1;
        o_cmd_wr = 1'h0;
        o_cmd_addr = ~a;
        o_cmd_wdata = ~d;
    endtask : wr
endmodule : chst_host_model

// ==== testbench/chst_status_regs_monitor.sv ====
/*
 * chst_status_regs_monitor: port-level checks of chst_status_regs.
 * assumes a bind from the bench top, one core clock.
 */
module chst_status_regs_monitor
    import chst_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_cmd_addr,
    input wire logic i_cmd_rd,
    input wire logic i_precharge,
    input wire logic i_reverse_supply,
    input wire logic i_input_ov,
    input wire logic i_system_ov,
    input wire logic i_thermal_shutdown,
    input wire logic i_adapter_present,
    input wire logic i_converter_shutoff_request,
    input wire logic i_assist_request,
    input wire logic [15:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_processor_hot_n,
    input wire logic o_converter_disable,
    input wire logic o_assist_active
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_rd_state;
        i_cmd_rd && i_cmd_addr == CHST_ADDR_STATE;
    endsequence
    sequence s_rd_hot;
        i_cmd_rd && i_cmd_addr == CHST_ADDR_HOT;
    endsequence

    // five held cycles cover two sync flops plus the latch
    a_prechg_live: assert property (
        i_precharge[*5] ##0 s_rd_state |=> o_rd_data[CHST_B_PRECHG])
        else $error("precharge flag missing");
    a_revsup_live: assert property (
        i_reverse_supply[*5] ##0 s_rd_state |=> o_rd_data[CHST_B_REVSUP])
        else $error("reverse supply flag missing");
    a_in_ov_seen: assert property (
        i_input_ov[*5] ##0 s_rd_state |=> o_rd_data[CHST_B_IN_OV])
        else $error("input overvoltage flag missing");
    a_shutoff_seen: assert property (
        i_converter_shutoff_request[*3] ##0 s_rd_state |=> o_rd_data[CHST_B_CONV_OFF])
        else $error("shutoff flag missing");
    a_sys_ov_off: assert property (
        (i_system_ov && i_adapter_present)[*6] |-> o_converter_disable)
        else $error("converter not disabled");
    a_thermal_shutdown_flag_seen: assert property (
        i_thermal_shutdown[*5] ##0 s_rd_hot |=> o_rd_data[CHST_B_THERMAL_SHUTDOWN_FLAG])
        else $error("thermal shutdown flag missing");
    a_rsvd_one: assert property (
        s_rd_hot |=> o_rd_valid && o_rd_data[CHST_B_RSVD])
        else $error("reserved bit not one");
    a_exit_holds: assert property (
        s_rd_hot ##1 o_rd_data[CHST_B_ASSIST_EXIT] |-> ##[0:2] !o_processor_hot_n)
        else $error("hot output high with exit flag");
    a_exit_pulls: assert property (
        $fell(o_assist_active) |-> ##[1:4] !o_processor_hot_n)
        else $error("assist exit left hot output high");
    a_enter_cmd: assert property (
        $rose(o_assist_active) |-> $past(i_assist_request))
        else $error("assist entered without request");
endmodule : chst_status_regs_monitor

// ==== testbench/tb_top.sv ====
/*
 * tb_top: self-checking bench for chst_status_regs.
 * assumes the host model for commands; pins change 1 ns after the edge.
 */
module tb_top
    import chst_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 1'h0;
    logic i_rst_n = 1'h0;
    logic [12:0] pin = 13'h0000;
    logic [6:0] prof = 7'h00;
    logic pt = 1'h0, boc_en = 1'h0, conv_off = 1'h0, req = 1'h0;
    logic [7:0] addr;
    logic rd, wr, vld, hot_n, cdis, act;
    logic [15:0] wdata, rdata;
    int miscompares = 0, num_checks = 0, cycles = 0;

    always #50 i_mclk = ~i_mclk;

    chst_host_model host (.i_mclk(i_mclk), .i_rd_data(rdata), .i_rd_valid(vld),
        .o_cmd_addr(addr), .o_cmd_rd(rd), .o_cmd_wr(wr), .o_cmd_wdata(wdata));
    chst_status_regs uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_addr(addr),
        .i_cmd_rd(rd), .i_cmd_wr(wr), .i_cmd_wdata(wdata), .i_precharge(pin[0]),
        .i_reverse_supply(pin[1]), .i_input_ov(pin[2]), .i_input_oc(pin[3]),
        .i_battery_oc(pin[4]), .i_battery_ov(pin[5]), .i_system_ov(pin[6]),
        .i_system_uv_fail(pin[7]), .i_reverse_ov(pin[8]), .i_reverse_uv(pin[9]),
        .i_thermal_shutdown(pin[10]), .i_assist_load_fail(pin[11]),
        .i_adapter_present(pin[12]), .i_profile_event(prof), .i_pass_through(pt),
        .i_battery_oc_enable(boc_en), .i_converter_shutoff_request(conv_off),
        .i_assist_request(req), .o_rd_data(rdata), .o_rd_valid(vld),
        .o_processor_hot_n(hot_n), .o_converter_disable(cdis), .o_assist_active(act));

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chk_rng(input string n, input int lo, input int hi, input int g);
        num_checks++;
        if (g < lo || g > hi) begin
            miscompares++;
            $display("[ERR] %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask : chk_rng
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : cyc
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask : rdc
    task automatic close_out();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic t_live();
        rdc(8'h21, 16'hb800);
        chk("hot_n", 16'h0001, 16'(hot_n));
        pin[CHST_S_PRECHG] = 1'h1;
        cyc(5);
        rdc(8'h20, 16'h0200);
        pin[CHST_S_PRECHG] = 1'h0;
        pin[CHST_S_REVSUP] = 1'h1;
        cyc(5);
        rdc(8'h20, 16'h0100);
        pin[CHST_S_REVSUP] = 1'h0;
        cyc(5);
        rdc(8'h20, 16'h0000);
    endtask : t_live

    task automatic t_sticky();
        int src[5] = '{CHST_S_IN_OV, CHST_S_IN_OC, CHST_S_BAT_OC, CHST_S_REV_OV, CHST_S_REV_UV};
        int bt[5] = '{CHST_B_IN_OV, CHST_B_IN_OC, CHST_B_BAT_OC, CHST_B_REV_OV, CHST_B_REV_UV};
        for (int i = 0; i < 5; i++) begin
            pin[src[i]] = 1'h1;
            cyc(5);
            rdc(8'h20, 16'h0001 << bt[i]);
            pin[src[i]] = 1'h0;
            cyc(5);
            rdc(8'h20, 16'h0001 << bt[i]);
            rdc(8'h20, 16'h0000);
        end
        conv_off = 1'h1;
        cyc(3);
        rdc(8'h20, 16'h0004);
        conv_off = 1'h0;
        rdc(8'h20, 16'h0004);
        rdc(8'h20, 16'h0000);
        pt = 1'h1;
        boc_en = 1'h1;
        pin[CHST_S_BAT_OV] = 1'h1;
        cyc(5);
        pin[CHST_S_BAT_OV] = 1'h0;
        cyc(5);
        rdc(8'h20, 16'h0040);
        pt = 1'h0;
        boc_en = 1'h0;
        rdc(8'h20, 16'h0000);
    endtask : t_sticky

    task automatic t_sysfault();
        pin[CHST_S_ADAPTER] = 1'h1;
        pin[CHST_S_SYS_OV] = 1'h1;
        cyc(6);
        chk("conv_disable", 16'h0001, 16'(cdis));
        pin[CHST_S_SYS_OV] = 1'h0;
        cyc(5);
        rdc(8'h20, 16'h0010);
        host.wr(8'h20, 16'hffff);
        rdc(8'h20, 16'h0010);
        host.wr(8'h20, 16'h0000);
        cyc(2);
        rdc(8'h20, 16'h0000);
        chk("conv_disable", 16'h0000, 16'(cdis));
        pin[CHST_S_SYS_OV] = 1'h1;
        cyc(5);
        pin[CHST_S_SYS_OV] = 1'h0;
        pin[CHST_S_ADAPTER] = 1'h0;
        cyc(5);
        rdc(8'h20, 16'h0000);
        pin[CHST_S_SYS_UV] = 1'h1;
        cyc(5);
        pin[CHST_S_SYS_UV] = 1'h0;
        cyc(5);
        rdc(8'h20, 16'h0008);
        host.wr(8'h20, 16'h0000);
        rdc(8'h20, 16'h0000);
    endtask : t_sysfault

    task automatic t_hot();
        int lens[3] = '{1000, 10000, 50000};
        int n, k;
        for (int w = 0; w < 3; w++) begin
            host.wr(8'h21, 16'h0800 | (16'(w) << 12));
            prof[0] = 1'h1;
            for (n = 0; n < 20 && hot_n !== 1'h0; n++) cyc(1);
            prof[0] = 1'h0;
            for (k = 0; k < 60000 && hot_n === 1'h0; k++) cyc(1);
            chk_rng("hot low cycles", lens[w], lens[w] + 3, k);
            rdc(8'h21, 16'h8801 | (16'(w) << 12));
            rdc(8'h21, 16'h8800 | (16'(w) << 12));
        end
        host.wr(8'h21, 16'h4800);
        prof[1] = 1'h1;
        cyc(3000);
        prof[1] = 1'h0;
        chk("hot_n", 16'h0000, 16'(hot_n));
        host.wr(8'h21, 16'h4000);
        cyc(4);
        chk("hot_n", 16'h0001, 16'(hot_n));
        rdc(8'h21, 16'hc802);
        host.wr(8'h21, 16'h3800);
    endtask : t_hot

    task automatic t_assist();
        req = 1'h1;
        cyc(2);
        chk("assist", 16'h0001, 16'(act));
        req = 1'h0;
        cyc(6);
        chk("hot_n", 16'h0000, 16'(hot_n));
        rdc(8'h21, 16'hb900);
        host.wr(8'h21, 16'h3800);
        cyc(3);
        chk("hot_n", 16'h0001, 16'(hot_n));
        req = 1'h1;
        cyc(2);
        pin[CHST_S_IN_OV] = 1'h1;
        cyc(5);
        chk("assist", 16'h0000, 16'(act));
        pin[CHST_S_IN_OV] = 1'h0;
        rdc(8'h21, 16'hb900);
        rdc(8'h20, 16'h0080);
        host.wr(8'h21, 16'h3800);
        req = 1'h0;
        cyc(2);
        req = 1'h1;
        cyc(2);
        pin[CHST_S_ASSIST_FAIL] = 1'h1;
        cyc(5);
        pin[CHST_S_ASSIST_FAIL] = 1'h0;
        chk("assist", 16'h0000, 16'(act));
        rdc(8'h21, 16'hbb00);
        req = 1'h0;
        cyc(2);
        req = 1'h1;
        cyc(2);
        chk("assist", 16'h0000, 16'(act));
        req = 1'h0;
        host.wr(8'h21, 16'h3800);
        cyc(3);
        rdc(8'h21, 16'hb800);
        pin[CHST_S_THERMAL_SHUTDOWN_FLAG] = 1'h1;
        cyc(5);
        rdc(8'h21, 16'hbc00);
        pin[CHST_S_THERMAL_SHUTDOWN_FLAG] = 1'h0;
        cyc(5);
        rdc(8'h21, 16'hbc00);
        rdc(8'h21, 16'hb800);
    endtask : t_assist

    // a hang ends in the same report as a normal run
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 80000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        repeat (12) @(posedge i_mclk);
        #1;
        i_rst_n = 1'h1;
        t_live();
        t_sticky();
        t_sysfault();
        t_hot();
        t_assist();
        close_out();
    end
endmodule : tb_top

bind chst_status_regs chst_status_regs_monitor mon (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_cmd_addr(i_cmd_addr), .i_cmd_rd(i_cmd_rd), .i_precharge(i_precharge),
    .i_reverse_supply(i_reverse_supply), .i_input_ov(i_input_ov), .i_system_ov(i_system_ov),
    .i_thermal_shutdown(i_thermal_shutdown), .i_adapter_present(i_adapter_present),
    .i_converter_shutoff_request(i_converter_shutoff_request),
    .i_assist_request(i_assist_request), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_processor_hot_n(o_processor_hot_n), .o_converter_disable(o_converter_disable),
    .o_assist_active(o_assist_active));
